// ---- logic/fudo_pkg.sv ----
// Constants, register map and state codes for the frequency update and fine offset block.
// Notes on behaviour
// - Written dividers reach outputs only at calibration start.
// - Writing 0x08 to register 7 starts calibration.
// - Calibration lasts about 30 ms before enable.
// - Writing 0x01 to 17 re-enables output synchronously.
// - Offset covers minus to plus 950 ppm.
// - Offset is 24-bit two's complement.
// - One offset step equals 0.0001164 ppm.
// - Offset applies only when register 233 written.
// - Offset applied synchronously, no output discontinuity.
// - Back-to-back offset updates at full bus rate.
// - Zero offset gives nominal frequency.
// - Register 24 packs low-speed and upper high-speed divider.
// - Feedback divider is 11.32 unsigned fixed point.
// - Gate bit 0 disables output; 1 returns pin control.
// - Calibration start bit clears itself.
package fudo_pkg;

  localparam logic [7:0] ADDR_CAL_CMD = 8'h07;
  localparam logic [7:0] ADDR_GATE = 8'h11;
  localparam logic [7:0] ADDR_HSD_LO = 8'h17;
  localparam logic [7:0] ADDR_PACKED = 8'h18;
  localparam logic [7:0] ADDR_FB0 = 8'h1A;
  localparam logic [7:0] ADDR_FB1 = 8'h1B;
  localparam logic [7:0] ADDR_FB2 = 8'h1C;
  localparam logic [7:0] ADDR_FB3 = 8'h1D;
  localparam logic [7:0] ADDR_FB4 = 8'h1E;
  localparam logic [7:0] ADDR_FB_TOP = 8'h1F;
  localparam logic [7:0] ADDR_BYPASS = 8'h45;
  localparam logic [7:0] ADDR_OFS_LO = 8'hE7;
  localparam logic [7:0] ADDR_OFS_MID = 8'hE8;
  localparam logic [7:0] ADDR_OFS_HI = 8'hE9;
  localparam logic [7:0] ADDR_PAGE = 8'hFF;

  localparam int BIT_RESET = 7;
  localparam int BIT_CAL_START = 3;
  localparam int BIT_GATE = 0;
  localparam int BIT_BYPASS = 0;
  localparam int LSD_MSB = 6;
  localparam int LSD_LSB = 4;
  localparam int HSD_HI_MSB = 2;
  localparam int FB_TOP_MSB = 2;
  localparam int PAGE_MSB = 1;

  localparam logic [10:0] RST_HSD = 11'h054;
  localparam logic [2:0] RST_LSD = 3'h0;
  localparam logic [42:0] RST_FB = 43'h064_0000_0000;
  localparam logic RST_GATE = 1'h1;
  localparam logic RST_BYPASS = 1'h1;
  localparam logic [1:0] PAGE_ZERO = 2'h0;

  // Largest code inside 950 ppm: floor(950 / 0.0001164) = 8161512.
  localparam logic [23:0] OFS_LIMIT = 24'h7C88E8;

  localparam int CAL_TIME_MS = 30;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int CAL_CYCLES_DEFAULT = CAL_TIME_MS * CLK_FREQ_KHZ;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_REG = 7'h04,
    ST_WDATA = 7'h08,
    ST_RDATA = 7'h10,
    ST_ACK = 7'h20,
    ST_MACK = 7'h40
  } fudo_state_type;

endpackage : fudo_pkg

// ---- logic/fudo_top.sv ----
// Serial register bank that stages divider updates, runs calibration timing and applies fine offsets.

////////////////////////////////////////////////////////////////////////////////

module fudo_sync
  #(parameter logic RST = 1'h1)
  (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic level
  );

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
      level <= RST;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        level <= s3;
      end
    end
  end

endmodule : fudo_sync

////////////////////////////////////////////////////////////////////////////////

module fudo_top
  import fudo_pkg::*;
  #(
  parameter logic [6:0] DEV_ADDR = 7'h55, // Arbitrary bus address.
  parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
  )
  (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic oe_pin,
  output logic [10:0] high_speed_divider,
  output logic [2:0] low_speed_divider,
  output logic [42:0] feedback_divider,
  output logic calibration_busy,
  output logic clock_enable,
  output logic [23:0] fine_frequency_offset,
  output logic offset_update,
  output logic offset_in_range
  );

  localparam int CW = $clog2(CAL_CYCLES + 1);

  logic scl_lvl;
  logic sda_lvl;
  logic oe_lvl;
  logic scl_q;
  logic sda_q;
  fudo_state_type state;
  fudo_state_type after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shifter;
  logic [7:0] ptr;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic [10:0] hsd;
  logic [2:0] lsd;
  logic [42:0] fb;
  logic gate_bit;
  logic bypass;
  logic [7:0] ofs_lo;
  logic [7:0] ofs_mid;
  logic [1:0] page_sel;
  logic soft_rst;
  logic [CW-1:0] cal_count;
  logic wr_ok;
  logic cal_kick;
  logic ofs_load;
  logic [23:0] next_offset;
  logic next_in_range;

  fudo_sync #(.RST(1'h1)) u_scl (.clk(clk), .nrst(nrst), .din(scl_in), .level(scl_lvl));
  fudo_sync #(.RST(1'h1)) u_sda (.clk(clk), .nrst(nrst), .din(sda_in), .level(sda_lvl));
  fudo_sync #(.RST(1'h1)) u_oe (.clk(clk), .nrst(nrst), .din(oe_pin), .level(oe_lvl));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial slave engine.

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end
    else
    begin
      scl_q <= scl_lvl;
      sda_q <= sda_lvl;
    end
  end

  wire start_cond = scl_lvl && scl_q && sda_q && !sda_lvl;
  wire stop_cond = scl_lvl && scl_q && !sda_q && sda_lvl;
  wire scl_rise = scl_lvl && !scl_q;
  wire scl_fall = !scl_lvl && scl_q;

  always_ff @(posedge clk)
  begin
    sda_out <= 1'h0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shifter <= 8'h00;
      ptr <= 8'h00;
      sda_oe <= 1'h0;
      wr_en <= 1'h0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_en <= 1'h0;
      if (start_cond)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'h0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE;
        sda_oe <= 1'h0;
      end
      else if (scl_rise)
      begin
        case (state)
          ST_ADDR, ST_REG, ST_WDATA:
          begin
            shifter <= {shifter[6:0], sda_lvl};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RDATA:
          begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_MACK:
          begin
            // A not-acknowledge ends the read burst.
            if (sda_lvl)
            begin
              state <= ST_IDLE;
            end
          end
          default:
          begin
          end
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          ST_ADDR:
          begin
            if (bit_cnt == BYTE_BITS)
            begin
              if (shifter[7:1] == DEV_ADDR)
              begin
                sda_oe <= 1'h1;
                after_ack <= shifter[0] ? ST_RDATA : ST_REG;
                state <= ST_ACK;
              end
              else
              begin
                state <= ST_IDLE;
              end
            end
          end
          ST_REG:
          begin
            if (bit_cnt == BYTE_BITS)
            begin
              ptr <= shifter;
              sda_oe <= 1'h1;
              after_ack <= ST_WDATA;
              state <= ST_ACK;
            end
          end
          ST_WDATA:
          begin
            // Auto-increment lets 231..233 go in one burst at full bus rate.
            if (bit_cnt == BYTE_BITS)
            begin
              wr_en <= 1'h1;
              wr_addr <= ptr;
              wr_data <= shifter;
              ptr <= ptr + 8'h01;
              sda_oe <= 1'h1;
              after_ack <= ST_WDATA;
              state <= ST_ACK;
            end
          end
          ST_ACK, ST_MACK:
          begin
            bit_cnt <= 4'h0;
            state <= after_ack;
            if (after_ack == ST_RDATA)
            begin
              shifter <= {rd_byte[6:0], 1'h0};
              sda_oe <= ~rd_byte[7];
              ptr <= ptr + 8'h01;
            end
            else
            begin
              sda_oe <= 1'h0;
            end
          end
          ST_RDATA:
          begin
            if (bit_cnt == BYTE_BITS)
            begin
              sda_oe <= 1'h0;
              state <= ST_MACK;
            end
            else
            begin
              sda_oe <= ~shifter[7];
              shifter <= {shifter[6:0], 1'h0};
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file. Only the page register answers while another page is chosen.

  assign wr_ok = wr_en && (page_sel == PAGE_ZERO || wr_addr == ADDR_PAGE);
  assign cal_kick = wr_ok && wr_addr == ADDR_CAL_CMD && wr_data[BIT_CAL_START];
  assign ofs_load = wr_ok && wr_addr == ADDR_OFS_HI;

  // The command register holds nothing: both its bits act for one cycle and read back as zero.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      soft_rst <= 1'h0;
    end
    else
    begin
      soft_rst <= wr_ok && wr_addr == ADDR_CAL_CMD && wr_data[BIT_RESET];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || soft_rst)
    begin
      hsd <= RST_HSD;
      lsd <= RST_LSD;
      fb <= RST_FB;
      gate_bit <= RST_GATE;
      bypass <= RST_BYPASS;
      ofs_lo <= 8'h00;
      ofs_mid <= 8'h00;
      page_sel <= PAGE_ZERO;
    end
    else if (wr_ok)
    begin
      case (wr_addr)
        ADDR_HSD_LO: hsd[7:0] <= wr_data;
        ADDR_PACKED:
        begin
          lsd <= wr_data[LSD_MSB:LSD_LSB];
          hsd[10:8] <= wr_data[HSD_HI_MSB:0];
        end
        ADDR_FB0: fb[7:0] <= wr_data;
        ADDR_FB1: fb[15:8] <= wr_data;
        ADDR_FB2: fb[23:16] <= wr_data;
        ADDR_FB3: fb[31:24] <= wr_data;
        ADDR_FB4: fb[39:32] <= wr_data;
        ADDR_FB_TOP: fb[42:40] <= wr_data[FB_TOP_MSB:0];
        ADDR_GATE: gate_bit <= wr_data[BIT_GATE];
        ADDR_BYPASS: bypass <= wr_data[BIT_BYPASS];
        ADDR_OFS_LO: ofs_lo <= wr_data;
        ADDR_OFS_MID: ofs_mid <= wr_data;
        ADDR_PAGE: page_sel <= wr_data[PAGE_MSB:0];
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (page_sel == PAGE_ZERO || ptr == ADDR_PAGE)
    begin
      case (ptr)
        ADDR_GATE: rd_byte = {7'h00, gate_bit};
        ADDR_HSD_LO: rd_byte = hsd[7:0];
        ADDR_PACKED: rd_byte = {1'h0, lsd, 1'h0, hsd[10:8]};
        ADDR_FB0: rd_byte = fb[7:0];
        ADDR_FB1: rd_byte = fb[15:8];
        ADDR_FB2: rd_byte = fb[23:16];
        ADDR_FB3: rd_byte = fb[31:24];
        ADDR_FB4: rd_byte = fb[39:32];
        ADDR_FB_TOP: rd_byte = {5'h00, fb[42:40]};
        ADDR_BYPASS: rd_byte = {7'h00, bypass};
        ADDR_OFS_LO: rd_byte = ofs_lo;
        ADDR_OFS_MID: rd_byte = ofs_mid;
        ADDR_OFS_HI: rd_byte = fine_frequency_offset[23:16];
        ADDR_PAGE: rd_byte = {6'h00, page_sel};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divider hand-over and calibration timing.

  // Writing divider bytes alone changes nothing downstream; the analog side only sees them here.
  always_ff @(posedge clk)
  begin
    if (!nrst || soft_rst)
    begin
      high_speed_divider <= RST_HSD;
      low_speed_divider <= RST_LSD;
      feedback_divider <= RST_FB;
    end
    else if (cal_kick)
    begin
      high_speed_divider <= hsd;
      low_speed_divider <= lsd;
      // Integer part sits in 42:32, fraction in 31:0.
      feedback_divider <= fb;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || soft_rst)
    begin
      calibration_busy <= 1'h0;
      cal_count <= '0;
    end
    else if (cal_kick)
    begin
      calibration_busy <= !bypass;
      cal_count <= CW'(CAL_CYCLES - 1);
    end
    else if (calibration_busy)
    begin
      if (cal_count == '0)
      begin
        calibration_busy <= 1'h0;
      end
      else
      begin
        cal_count <= cal_count - CW'(1);
      end
    end
  end

  // The output follows calibration_busy one cycle late, so it stays on for the first calibration cycle and goes dark after that.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      clock_enable <= 1'h0;
    end
    else
    begin
      clock_enable <= gate_bit && oe_lvl && !calibration_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fine offset. Each code step is 0.0001164 ppm; zero gives the nominal frequency.

  assign next_offset = {wr_data, ofs_mid, ofs_lo};
  assign next_in_range = ($signed(next_offset) <= $signed(OFS_LIMIT))
    && ($signed(next_offset) >= -$signed(OFS_LIMIT));

  always_ff @(posedge clk)
  begin
    if (!nrst || soft_rst)
    begin
      fine_frequency_offset <= 24'h000000;
      offset_update <= 1'h0;
      offset_in_range <= 1'h1;
    end
    else
    begin
      offset_update <= ofs_load;
      if (ofs_load)
      begin
        fine_frequency_offset <= next_offset;
        offset_in_range <= next_in_range;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  a_div_hold: assert property (!cal_kick && !soft_rst |=> $stable(feedback_divider))
    else $error("dividers changed without calibration start");
  a_div_load: assert property (cal_kick |=> feedback_divider == $past(fb)
    && low_speed_divider == $past(lsd) && high_speed_divider == $past(hsd))
    else $error("dividers not taken at calibration start");
  a_cal_wait: assert property ($rose(calibration_busy) |-> calibration_busy [*8])
    else $error("calibration wait ended early");
  a_cal_clear: assert property (calibration_busy && cal_count == '0 && !cal_kick && !soft_rst
    |=> !calibration_busy)
    else $error("calibration did not finish");
  a_gate_off: assert property (!gate_bit |=> !clock_enable)
    else $error("output on while gate bit clear");
  a_gate_on: assert property (gate_bit && oe_lvl && !calibration_busy |=> clock_enable)
    else $error("output not enabled");
  a_ofs_apply: assert property (ofs_load |=> offset_update
    && fine_frequency_offset == {$past(wr_data), $past(ofs_mid), $past(ofs_lo)})
    else $error("offset not applied on top byte");
  a_ofs_shadow: assert property (!ofs_load && !soft_rst |=> $stable(fine_frequency_offset))
    else $error("offset changed before top byte");

endmodule : fudo_top

// ---- dv/fudo_host.sv ----
// I2C host model that programs the block over its serial register bus.

////////////////////////////////////////////////////////////

module fudo_host
  (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
  );
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] adr = 7'h55;
  int nacks = 0;

  // The data line is only ever released, never driven high, so the pull-up sets idle.
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask : q

  // SCL toggles only inside a frame and stands high between frames.
  task automatic bt(input logic b, output logic r);
    q(4);
    sda_drv = b;
    q(4);
    scl = 1'b1;
    q(4);
    r = sda;
    q(4);
    scl = 1'b0;
  endtask : bt

  task automatic start();
    q(4);
    sda_drv = 1'b1;
    q(4);
    scl = 1'b1;
    q(4);
    sda_drv = 1'b0;
    q(4);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    q(4);
    sda_drv = 1'b0;
    q(4);
    scl = 1'b1;
    q(4);
    sda_drv = 1'b1;
    q(8);
  endtask : stop

  task automatic tx(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(b[i], r);
    bt(1'b1, r);
    if (r !== 1'b0)
      nacks++;
  endtask : tx

  // Low byte goes first, so a three-byte burst from 231 ends on the top offset byte.
  task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n);
    start();
    tx({adr, 1'b0});
    tx(a);
    for (int i = 0; i < n; i++)
      tx(d[8*i+:8]);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    tx({adr, 1'b0});
    tx(a);
    start();
    tx({adr, 1'b1});
    for (int i = 7; i >= 0; i--)
      bt(1'b1, d[i]);
    bt(1'b1, r);
    stop();
  endtask : rd
endmodule : fudo_host

// ---- dv/fudo_top_tb.sv ----
// Self-checking bench for the frequency update and fine offset block.

////////////////////////////////////////////////////////////

module fudo_top_tb
  import fudo_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CAL = 40;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic oe_pin = 1'b1;
  logic scl;
  logic host_sda;
  logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic [10:0] high_speed_divider;
  logic [2:0] low_speed_divider;
  logic [42:0] feedback_divider;
  logic calibration_busy;
  logic clock_enable;
  logic [23:0] fine_frequency_offset;
  logic offset_update;
  logic offset_in_range;
  logic busy_q = 1'b0;
  int errors = 0;
  int n_tests = 0;
  int n_upd = 0;
  int n_cal = 0;
  int bcnt = 0;
  int blen = 0;
  int ce_bad = 0;
  // Fields: address, reset value, written value, value read back.
  logic [31:0] rows [15] = '{32'hFF00_0000, 32'h4501_0000, 32'h1101_0000, 32'h1754_4646,
    32'h1800_3232, 32'h1A00_BFBF, 32'h1B00_F2F2, 32'h1C00_9C9C, 32'h1D00_5151, 32'h1E64_C7C7,
    32'h1F00_0101, 32'hE700_1212, 32'hE800_3434, 32'h5000_A500, 32'h4500_0000};
  // Top bit is the expected in-range flag.
  logic [24:0] ofs [6] = '{25'h1FF_FFFF, 25'h17C_88E8, 25'h07C_88E9, 25'h183_7718, 25'h083_7717,
    25'h100_0000};

  always #2.5 clk = ~clk;
  assign sda_wire = host_sda & ~(sda_oe & ~sda_out);

  fudo_top #(.CAL_CYCLES(CAL)) dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .oe_pin(oe_pin), .high_speed_divider(high_speed_divider),
    .low_speed_divider(low_speed_divider), .feedback_divider(feedback_divider),
    .calibration_busy(calibration_busy), .clock_enable(clock_enable),
    .fine_frequency_offset(fine_frequency_offset), .offset_update(offset_update),
    .offset_in_range(offset_in_range));

  fudo_host host (.clk(clk), .sda(sda_wire), .scl(scl), .sda_drv(host_sda));

  always @(posedge clk)
  begin
    busy_q <= calibration_busy;
    if (offset_update === 1'b1)
      n_upd <= n_upd + 1;
    if (calibration_busy === 1'b1)
      bcnt <= bcnt + 1;
    else if (busy_q === 1'b1)
    begin
      blen <= bcnt;
      bcnt <= 0;
      n_cal <= n_cal + 1;
    end
    if (busy_q === 1'b1 && calibration_busy === 1'b1 && clock_enable === 1'b1)
      ce_bad <= ce_bad + 1;
  end

  ////////////////////////////////////////////////////////////

  task automatic chk(input logic [42:0] got, input logic [42:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_r(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(43'(d), 43'(exp));
  endtask : chk_r

  task automatic chk_div(input logic [10:0] hs, input logic [2:0] ls, input logic [42:0] fb);
    chk(43'(high_speed_divider), 43'(hs));
    chk(43'(low_speed_divider), 43'(ls));
    chk(feedback_divider, fb);
  endtask : chk_div

  task automatic rst_dut();
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
  endtask : rst_dut

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic end_of_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////

  initial
  begin
    repeat (95000) @(posedge clk);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    rst_dut();
    chk_div(RST_HSD, RST_LSD, RST_FB);
    chk(43'(fine_frequency_offset), 43'h0);
    chk(43'(clock_enable), 43'h1);
    done("reset");
    foreach (rows[i])
    begin
      chk_r(rows[i][31:24], rows[i][23:16]);
      host.wr(rows[i][31:24], {16'h0, rows[i][15:8]}, 1);
      chk_r(rows[i][31:24], rows[i][7:0]);
    end
    chk_div(RST_HSD, RST_LSD, RST_FB);
    chk(43'(fine_frequency_offset), 43'h0);
    chk(43'(clock_enable), 43'h0);
    done("register table");
    host.wr(ADDR_CAL_CMD, 24'h08, 1);
    chk_div(11'h246, 3'h3, 43'h1C7_519C_F2BF);
    chk_r(ADDR_CAL_CMD, 8'h00);
    chk(43'(blen), 43'(CAL));
    host.wr(ADDR_GATE, 24'h01, 1);
    chk(43'(clock_enable), 43'h1);
    host.wr(ADDR_CAL_CMD, 24'h08, 1);
    chk_r(ADDR_HSD_LO, 8'h46);
    chk(43'(ce_bad), 43'h0);
    chk(43'(n_cal), 43'h2);
    host.wr(ADDR_BYPASS, 24'h01, 1);
    host.wr(ADDR_CAL_CMD, 24'h08, 1);
    chk(43'(n_cal), 43'h2);
    chk(43'(clock_enable), 43'h1);
    done("calibration");
    host.wr(ADDR_GATE, 24'h00, 1);
    chk(43'(clock_enable), 43'h0);
    host.wr(ADDR_GATE, 24'h01, 1);
    oe_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk(43'(clock_enable), 43'h0);
    oe_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk(43'(clock_enable), 43'h1);
    done("gate");
    foreach (ofs[i])
    begin
      host.wr(ADDR_OFS_LO, ofs[i][23:0], 3);
      chk(43'(fine_frequency_offset), 43'(ofs[i][23:0]));
      chk(43'(offset_in_range), 43'(ofs[i][24]));
      chk(43'(n_upd), 43'(i + 1));
    end
    host.wr(ADDR_OFS_LO, 24'h56, 1);
    host.wr(ADDR_OFS_MID, 24'h34, 1);
    chk(43'(fine_frequency_offset), 43'h0);
    host.wr(ADDR_OFS_HI, 24'h12, 1);
    chk(43'(fine_frequency_offset), 43'h12_3456);
    done("offset");
    host.wr(ADDR_PAGE, 24'h01, 1);
    host.wr(ADDR_HSD_LO, 24'h11, 1);
    chk_r(ADDR_HSD_LO, 8'h00);
    host.wr(ADDR_PAGE, 24'h00, 1);
    chk_r(ADDR_HSD_LO, 8'h46);
    chk(43'(host.nacks), 43'h0);
    host.adr = 7'h2A;
    host.wr(ADDR_GATE, 24'h00, 1);
    chk(43'(host.nacks), 43'h3);
    host.adr = 7'h55;
    chk(43'(clock_enable), 43'h1);
    done("page and address");
    host.wr(ADDR_CAL_CMD, 24'h80, 1);
    chk_div(RST_HSD, RST_LSD, RST_FB);
    chk_r(ADDR_HSD_LO, 8'h54);
    chk(43'(fine_frequency_offset), 43'h0);
    host.wr(ADDR_OFS_LO, 24'h7C_88E9, 3);
    chk(43'(offset_in_range), 43'h0);
    rst_dut();
    chk(43'(fine_frequency_offset), 43'h0);
    chk(43'(offset_in_range), 43'h1);
    chk(43'(clock_enable), 43'h1);
    done("soft and hard reset");
    end_of_test();
  end
endmodule : fudo_top_tb
